// >>> test/tdl_backplane_model.sv
// backplane ttl trigger lines: pull-ups plus other modules asserting
`timescale 1ns/1ps
module tdl_backplane_model (
  input  logic [7:0] ttlTriggerOe,
  input  logic [7:0] otherAssert,
  output logic [7:0] ttlTriggerIn_n
);
  // wired-or open collector, high when released
  assign ttlTriggerIn_n = ~(ttlTriggerOe | otherAssert);
endmodule // tdl_backplane_model

// >>> test/tdl_trigger_drive_sva.sv
// assertions on the trigger drive register ports
`timescale 1ns/1ps
module tdl_trigger_drive_sva (
  input logic        mclk,
  input logic        rst_n,
  input logic        softReset,
  input logic [5:0]  regAddr,
  input logic        regWrite,
  input logic        regRead,
  input logic [15:0] regWrData,
  input logic [15:0] regRdData,
  input logic [7:0]  logicalAddressSwitch,
  input logic [2:0]  outputTriggerProtocolSelect,
  input logic [3:0]  outputTriggerLineSelect,
  input logic [7:0]  ttlTriggerOut_n,
  input logic [7:0]  ttlTriggerOe,
  input logic [1:0]  eclTriggerDrive
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire       hit  = regAddr == 6'h26;
  wire       idle = outputTriggerProtocolSelect == 3'h0;
  wire [2:0] sel  = outputTriggerLineSelect[2:0];
  sequence tailS;
    (!regWrite && !softReset && idle)[*8] ##1 !softReset ##1 1'b1;
  endsequence
  sequence setS;
    regWrite && hit && regWrData[2] && !softReset && idle ##1 tailS;
  endsequence
  chk_out_low: assert property (ttlTriggerOut_n == 8'h00)
    else $error("ttl data not low");
  chk_rst_idle: assert property (disable iff (1'b0) !rst_n |-> ttlTriggerOe == 8'h00 && eclTriggerDrive == 2'h0)
    else $error("lines driven in reset");
  chk_la_read: assert property (regRead && hit |=> regRdData[7:0] == logicalAddressSwitch)
    else $error("bad address readback");
  chk_unmapped_rd: assert property (regRead && !hit |=> $stable(regRdData))
    else $error("unmapped read changed data");
  chk_ttl_level: assert property (setS |-> ttlTriggerOe == $past(regWrData[15:8], 10))
    else $error("ttl level wrong");
  chk_ecl_level: assert property (setS |-> eclTriggerDrive == $past(regWrData[1:0], 10))
    else $error("ecl level wrong");
  chk_soft_clear: assert property (softReset ##1 tailS |-> ttlTriggerOe == 8'h00 && eclTriggerDrive == 2'h0)
    else $error("soft reset left lines driven");
  chk_pulse_len: assert property (outputTriggerProtocolSelect == 3'h1 && !outputTriggerLineSelect[3]
    && $rose(ttlTriggerOe[sel]) |-> ttlTriggerOe[sel][*4] ##1 !ttlTriggerOe[sel])
    else $error("pulse not four cycles");
endmodule // tdl_trigger_drive_sva
bind tdl_trigger_drive tdl_trigger_drive_sva chk (.mclk, .rst_n, .softReset, .regAddr, .regWrite, .regRead,
  .regWrData, .regRdData, .logicalAddressSwitch, .outputTriggerProtocolSelect, .outputTriggerLineSelect,
  .ttlTriggerOut_n, .ttlTriggerOe, .eclTriggerDrive);

// >>> test/tdl_trigger_drive_tb_top.sv
// self-checking bench for the trigger drive register
`timescale 1ns/1ps
module tdl_trigger_drive_tb_top;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b1;
  logic        softReset = 1'b0;
  logic [5:0]  regAddr = 6'h26;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [15:0] regWrData = 16'h0000;
  logic [7:0]  logicalAddressSwitch = 8'h5A;
  logic [2:0]  oms = 3'h0;
  logic [3:0]  ots = 4'h0;
  logic [7:0]  otherAssert = 8'h00;
  wire  [15:0] regRdData;
  wire  [7:0]  ttlTriggerIn_n;
  wire  [7:0]  ttlTriggerOe;
  wire  [1:0]  eclTriggerDrive;
  wire  [9:0]  lines = {eclTriggerDrive, ttlTriggerOe};
  int          fail_count = 0;
  int          n_checks = 0;
  int          cycles = 0;
  tdl_trigger_drive uut (.mclk, .rst_n, .softReset, .regAddr, .regWrite, .regRead, .regWrData, .regRdData,
    .logicalAddressSwitch, .outputTriggerProtocolSelect(oms), .outputTriggerLineSelect(ots), .ttlTriggerIn_n,
    .ttlTriggerOut_n(), .ttlTriggerOe, .eclTriggerDrive);
  tdl_backplane_model bus (.ttlTriggerOe, .otherAssert, .ttlTriggerIn_n);
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      final_report;
    end
  end
  task final_report;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task wr(input logic [15:0] d);
    regAddr = 6'h26;
    regWrData = d;
    regWrite = 1'b1;
    @(posedge mclk);
    #1 regWrite = 1'b0;
  endtask
  task rd(input logic [5:0] a, input logic [15:0] exp);
    regAddr = a;
    regRead = 1'b1;
    @(posedge mclk);
    #1 regRead = 1'b0;
    chk(regRdData, exp);
    @(posedge mclk);
    #1;
  endtask
  task settle;
    repeat (12) @(posedge mclk);
    #1;
  endtask
  task pulse(input logic [3:0] sel, input logic [15:0] d, input logic [15:0] exp);
    logic [15:0] n;
    n = 16'h0000;
    wr(d);
    repeat (16) begin
      @(posedge mclk);
      #1 n = n + lines[sel];
    end
    chk(n, exp);
  endtask
  initial begin
    #1 rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge mclk);
    #1 rd(6'h26, 16'h005A);
    wr(16'hA507);
    settle;
    chk({6'h00, lines}, 16'h03A5);
    otherAssert = 8'h10;
    rd(6'h24, 16'h005A);
    rd(6'h26, 16'hB55A);
    otherAssert = 8'h00;
    softReset = 1'b1;
    @(posedge mclk);
    #1 softReset = 1'b0;
    settle;
    chk({6'h00, lines}, 16'h0000);
    oms = 3'h1;
    ots = 4'h3;
    pulse(4'h3, 16'h0000, 16'h0004);
    pulse(4'h3, 16'h0000, 16'h0000);
    pulse(4'h3, 16'h0004, 16'h0000);
    pulse(4'h3, 16'h0000, 16'h0004);
    ots = 4'h8;
    pulse(4'h8, 16'h0004, 16'h0000);
    pulse(4'h8, 16'h0000, 16'h0004);
    ots = 4'h9;
    pulse(4'h9, 16'h0004, 16'h0000);
    pulse(4'h9, 16'h0000, 16'h0004);
    oms = 3'h2;
    ots = 4'h5;
    pulse(4'h5, 16'h0004, 16'h0000);
    wr(16'h0000);
    settle;
    chk({6'h00, lines}, 16'h0020);
    wr(16'h0004);
    settle;
    chk({6'h00, lines}, 16'h0000);
    oms = 3'h0;
    pulse(4'h5, 16'h0000, 16'h0000);
    wr(16'h0307);
    settle;
    chk({6'h00, lines}, 16'h0303);
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk({6'h00, lines}, 16'h0000);
    rst_n = 1'b1;
    settle;
    chk({6'h00, lines}, 16'h0000);
    rd(6'h26, 16'h005A);
    final_report;
  end
endmodule // tdl_trigger_drive_tb_top

// >>> verilog/tdl_regs_defs.vh
// register offsets, fields, reset values and timing for the trigger drive register
`ifndef TDL_REGS_DEFS_VH
`define TDL_REGS_DEFS_VH

`define TDL_ADDR_W          6
`define TDL_DRIVE_LA_OFFSET 6'h26

`define TDL_TTL_MSB         15
`define TDL_TTL_LSB         8
`define TDL_LA_MSB          7
`define TDL_LA_LSB          0
`define TDL_PULSE_BIT       2
`define TDL_ECL1_BIT        1
`define TDL_ECL0_BIT        0

`define TDL_TTL_RESET       8'h00
`define TDL_ECL_RESET       2'h0
`define TDL_PULSE_RESET     1'h0

`define TDL_OMS_DISABLED    3'h0
`define TDL_OMS_SOURCE      3'h1
`define TDL_OMS_STARTSTOP   3'h2

`define TDL_OTS_ECL0        4'h8
`define TDL_OTS_ECL1        4'h9

`define TDL_MCLK_HZ         40000000
`define TDL_SYNC_HZ         10000000
`define TDL_SYNC_DIV        (`TDL_MCLK_HZ / `TDL_SYNC_HZ)
`define TDL_TICK_LAST       2'h3
`define TDL_PULSE_NS        100
`define TDL_MCLK_NS         25
`define TDL_PULSE_CYC       ((`TDL_PULSE_NS + `TDL_MCLK_NS - 1) / `TDL_MCLK_NS)

`endif

// >>> verilog/tdl_sync_stage.v
// two flip-flop retiming stage advancing on the 10 MHz tick
`timescale 1ns/1ps
module tdl_sync_stage #(
  parameter WIDTH = 10
) (
  input  wire             mclk,
  input  wire             rstSync_n,
  input  wire             tick,
  input  wire [WIDTH-1:0] reqIn,
  output reg  [WIDTH-1:0] lineOut
);

  reg [WIDTH-1:0] stage1_r;

  always @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      stage1_r <= {WIDTH{1'b0}};
      lineOut  <= {WIDTH{1'b0}};
    end else if (tick) begin
      stage1_r <= reqIn;
      lineOut  <= stage1_r;
    end
  end

endmodule // tdl_sync_stage

// >>> verilog/tdl_trigger_drive.v
// trigger drive and logical address register with synchronised line drivers
`timescale 1ns/1ps
`include "tdl_regs_defs.vh"
module tdl_trigger_drive (
  input  wire                   mclk,
  input  wire                   rst_n,
  input  wire                   softReset,
  input  wire [`TDL_ADDR_W-1:0] regAddr,
  input  wire                   regWrite,
  input  wire                   regRead,
  input  wire [15:0]            regWrData,
  output reg  [15:0]            regRdData,
  input  wire [7:0]             logicalAddressSwitch,
  input  wire [2:0]             outputTriggerProtocolSelect,
  input  wire [3:0]             outputTriggerLineSelect,
  input  wire [7:0]             ttlTriggerIn_n,
  output reg  [7:0]             ttlTriggerOut_n,
  output wire [7:0]             ttlTriggerOe,
  output wire [1:0]             eclTriggerDrive
);

  reg  [1:0]  rstPipe_r;
  wire        rstSync_n;
  reg  [1:0]  divCnt_r;
  wire        tick;
  reg  [7:0]  ttlTriggerDrive_r;
  reg  [7:0]  ttlTriggerDrive_nxt;
  reg         eclLine1Drive_r;
  reg         eclLine1Drive_nxt;
  reg         eclLine0Drive_r;
  reg         eclLine0Drive_nxt;
  reg         pulseArmed_r;
  reg         pulseArmed_nxt;
  reg         pulsePend_r;
  reg         pulsePend_nxt;
  reg         pulseOn_r;
  reg         pulseOn_nxt;
  reg         startLevel_r;
  reg         startLevel_nxt;
  reg  [7:0]  ttlLive_r;
  reg  [7:0]  logicalAddressReadback_r;
  wire        wrHit;
  wire        rdHit;
  wire        pulseZeroWr;
  wire        pulseOneWr;
  wire        srcFire;
  wire        startFire;
  reg  [9:0]  selMask;
  wire [9:0]  lineReq;
  wire [9:0]  lineDrive;

  // reset release through two flops
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_r <= 2'h0;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe_r[1];

  // 10 MHz tick from the 40 MHz clock
  always @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      divCnt_r <= 2'h0;
    end else begin
      divCnt_r <= divCnt_r + 2'h1;
    end
  end
  assign tick = (divCnt_r == `TDL_TICK_LAST);

  assign wrHit       = regWrite && (regAddr == `TDL_DRIVE_LA_OFFSET);
  assign rdHit       = regRead && (regAddr == `TDL_DRIVE_LA_OFFSET);
  assign pulseZeroWr = wrHit && !regWrData[`TDL_PULSE_BIT];
  assign pulseOneWr  = wrHit && regWrData[`TDL_PULSE_BIT];

  // mode qualified pulse requests
  assign srcFire     = pulseZeroWr && pulseArmed_r && (outputTriggerProtocolSelect == `TDL_OMS_SOURCE);
  assign startFire   = pulseZeroWr && pulseArmed_r && (outputTriggerProtocolSelect == `TDL_OMS_STARTSTOP);

  // writable bits; bits seven to three are ignored on write
  always @* begin
    ttlTriggerDrive_nxt = ttlTriggerDrive_r;
    eclLine1Drive_nxt   = eclLine1Drive_r;
    eclLine0Drive_nxt   = eclLine0Drive_r;
    if (softReset) begin
      ttlTriggerDrive_nxt = `TDL_TTL_RESET;
      eclLine1Drive_nxt   = 1'b0;
      eclLine0Drive_nxt   = 1'b0;
    end else if (wrHit) begin
      ttlTriggerDrive_nxt = regWrData[`TDL_TTL_MSB:`TDL_TTL_LSB];
      eclLine1Drive_nxt   = regWrData[`TDL_ECL1_BIT];
      eclLine0Drive_nxt   = regWrData[`TDL_ECL0_BIT];
    end
  end

  // drive bit registers
  always @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ttlTriggerDrive_r <= `TDL_TTL_RESET;
      eclLine1Drive_r   <= 1'b0;
      eclLine0Drive_r   <= 1'b0;
    end else begin
      ttlTriggerDrive_r <= ttlTriggerDrive_nxt;
      eclLine1Drive_r   <= eclLine1Drive_nxt;
      eclLine0Drive_r   <= eclLine0Drive_nxt;
    end
  end

  // pulse and start/stop sequencing
  always @* begin
    pulseArmed_nxt = pulseArmed_r;
    pulsePend_nxt  = pulsePend_r;
    pulseOn_nxt    = pulseOn_r;
    startLevel_nxt = startLevel_r;
    if (softReset) begin
      pulseArmed_nxt = 1'b1;
      pulsePend_nxt  = 1'b0;
      pulseOn_nxt    = 1'b0;
      startLevel_nxt = 1'b0;
    end else begin
      if (pulseOneWr) begin
        pulseArmed_nxt = 1'b1;
      end else if (pulseZeroWr) begin
        pulseArmed_nxt = 1'b0;
      end
      if (tick) begin
        pulseOn_nxt   = pulsePend_r;
        pulsePend_nxt = 1'b0;
      end
      if (srcFire) begin
        pulsePend_nxt = 1'b1;
      end
      if (pulseOneWr) begin
        startLevel_nxt = 1'b0;
      end else if (startFire) begin
        startLevel_nxt = 1'b1;
      end
    end
  end

  // pulse state registers
  always @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pulseArmed_r <= 1'b1;
      pulsePend_r  <= 1'b0;
      pulseOn_r    <= 1'b0;
      startLevel_r <= 1'b0;
    end else begin
      pulseArmed_r <= pulseArmed_nxt;
      pulsePend_r  <= pulsePend_nxt;
      pulseOn_r    <= pulseOn_nxt;
      startLevel_r <= startLevel_nxt;
    end
  end

  // output line select decode
  always @* begin
    selMask = 10'h000;
    case (outputTriggerLineSelect)
      4'h0: selMask = 10'h001;
      4'h1: selMask = 10'h002;
      4'h2: selMask = 10'h004;
      4'h3: selMask = 10'h008;
      4'h4: selMask = 10'h010;
      4'h5: selMask = 10'h020;
      4'h6: selMask = 10'h040;
      4'h7: selMask = 10'h080;
      `TDL_OTS_ECL0: selMask = 10'h100;
      `TDL_OTS_ECL1: selMask = 10'h200;
      default: selMask = 10'h000;
    endcase
  end

  assign lineReq = {eclLine1Drive_r, eclLine0Drive_r, ttlTriggerDrive_r}
                 | (selMask & {10{pulseOn_r | startLevel_r}});

  tdl_sync_stage #(
    .WIDTH(10)
  ) uLineSync (
    .mclk     (mclk),
    .rstSync_n(rstSync_n),
    .tick     (tick),
    .reqIn    (lineReq),
    .lineOut  (lineDrive)
  );

  assign ttlTriggerOe    = lineDrive[7:0];
  assign eclTriggerDrive = lineDrive[9:8];

  // open-collector low level, live line state and read data
  always @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ttlTriggerOut_n          <= 8'h00;
      ttlLive_r                <= 8'h00;
      logicalAddressReadback_r <= 8'h00;
      regRdData                <= 16'h0000;
    end else begin
      ttlTriggerOut_n          <= 8'h00;
      ttlLive_r                <= ~ttlTriggerIn_n;
      logicalAddressReadback_r <= logicalAddressSwitch;
      if (rdHit) begin
        regRdData <= {ttlLive_r, logicalAddressReadback_r};
      end
    end
  end

endmodule // tdl_trigger_drive
